// File: fld_pkg.sv
// Constants and types shared by the fault latch diagnostics block.
package fld_pkg;

   // =========================================================
   // Widths
   // =========================================================
   localparam int FLD_SIG_W = 32;
   localparam int FLD_CODE_W = 16;
   localparam int FLD_ADDR_W = 16;
   localparam int FLD_DATA_W = 32;
   localparam int FLD_STAT_W = 16;

   // =========================================================
   // Parameter addresses on the read port
   // =========================================================
   localparam logic [15:0] FLD_ADR_STOP_CODE = 16'h1c0a;
   localparam logic [15:0] FLD_ADR_SIG_LATCH = 16'h1c10;
   localparam logic [15:0] FLD_ADR_WARN_CODE = 16'h1c12;

   // =========================================================
   // Monitoring latch layout
   // =========================================================
   // Reserved positions are 7, 9, 12, 19, 24 and 25.
   localparam logic [31:0] FLD_RSV_MASK = 32'h0308_1280;
   localparam logic [31:0] FLD_LATCH_MASK = ~FLD_RSV_MASK;

   // =========================================================
   // Process status word positions owned by this block
   // =========================================================
   localparam int FLD_STAT_WARN_BIT = 7;
   localparam int FLD_STAT_STOP_BIT = 13;

   // =========================================================
   // Reset values
   // =========================================================
   localparam logic [31:0] FLD_LATCH_RST = 32'h0000_0000;
   localparam logic [15:0] FLD_CODE_RST = 16'h0000;
   localparam logic [31:0] FLD_DATA_RST = 32'h0000_0000;

   // =========================================================
   // Error classes
   // =========================================================
   typedef enum logic [2:0] {
      FLD_CLS_0 = 3'h0,
      FLD_CLS_1 = 3'h1,
      FLD_CLS_2 = 3'h2,
      FLD_CLS_3 = 3'h3,
      FLD_CLS_4 = 3'h4
   } fld_err_class_t;

endpackage : fld_pkg

// File: fld_sync.sv
// Two-stage synchroniser for the monitoring condition inputs.
`timescale 1ns/1ps

module fld_sync (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [fld_pkg::FLD_SIG_W-1:0] i_async,
   output logic [fld_pkg::FLD_SIG_W-1:0] o_sync
);
   import fld_pkg::*;

   // =========================================================
   // Per-bit flop pairs
   // =========================================================
   // The first stage feeds only the second stage, so a metastable
   // level never reaches the latch logic.
   genvar gi;
   generate
      for (gi = 0; gi < FLD_SIG_W; gi++) begin : g_bit
         logic meta_r;
         logic sync_r;
         always_ff @(posedge i_clk) begin
            if (i_rst) begin
               meta_r <= 1'b0;
               sync_r <= 1'b0;
            end else begin
               meta_r <= i_async[gi];
               sync_r <= meta_r;
            end
         end
         assign o_sync[gi] = sync_r;
      end
   endgenerate

endmodule : fld_sync

// File: fld_stop_code.sv
// Holder for the code of the error that caused a stop.
`timescale 1ns/1ps

module fld_stop_code (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_err_stb,
   input wire fld_pkg::fld_err_class_t i_err_class,
   input wire logic [fld_pkg::FLD_CODE_W-1:0] i_err_code,
   input wire logic i_fault_clr,
   output logic o_take,
   output logic [fld_pkg::FLD_CODE_W-1:0] o_code
);
   import fld_pkg::*;

   logic held_r;
   logic held_nxt;
   logic [FLD_CODE_W-1:0] code_r;
   logic [FLD_CODE_W-1:0] code_nxt;
   logic is_stop_cls;
   logic is_cls4;

   // =========================================================
   // Acceptance
   // =========================================================
   // A follow-on error must not hide its root cause, so only the
   // first stopping error is kept; class 4 is let through anyway.
   assign is_cls4 = (i_err_class == FLD_CLS_4);
   assign is_stop_cls = (i_err_class == FLD_CLS_1) ||
                        (i_err_class == FLD_CLS_2) ||
                        (i_err_class == FLD_CLS_3) || is_cls4;
   assign o_take = i_err_stb && is_stop_cls &&
                   (i_err_code != FLD_CODE_RST) &&
                   (!held_r || is_cls4);

   // A taken code wins over a fault reset in the same cycle; a class 1-3 code refused because one is held is lost.
   assign code_nxt = o_take ? i_err_code :
                     i_fault_clr ? FLD_CODE_RST : code_r;
   assign held_nxt = o_take | (held_r & ~i_fault_clr);

   // Code and held flag.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         code_r <= FLD_CODE_RST;
         held_r <= 1'b0;
      end else begin
         code_r <= code_nxt;
         held_r <= held_nxt;
      end
   end

   assign o_code = code_r;

   // =========================================================
   // Checks
   // =========================================================
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   property p_cls4_overwrite;
      (i_err_stb && is_cls4 && (i_err_code != FLD_CODE_RST))
         |=> (code_r == $past(i_err_code));
   endproperty
   a_cls4_overwrite: assert property (p_cls4_overwrite)
      else $error("Class 4 error did not replace the stop code.");

   property p_no_overwrite;
      (held_r && i_err_stb && !is_cls4 && !i_fault_clr)
         |=> $stable(code_r);
   endproperty
   a_no_overwrite: assert property (p_no_overwrite)
      else $error("Held stop code was replaced by a later error.");

endmodule : fld_stop_code

// File: fld_top.sv
// Latched diagnostics: monitoring latch, warning and stop codes.
`timescale 1ns/1ps

// Summary of operation
// - Latch bits 0-4: general to operating mode.
// - Bits 5, 6 interfaces; bit 8 following error.
// - Bits 10, 11 safe torque off; 13-15 supply.
// - Bits 16-18 encoder, temperatures; 20-23 modules.
// - Bits 26-31 motor, reference, memory, system.
// - Bits 7,9,12,19,24,25 reserved, never set.
// - Warning code holds latest class 0 code.
// - Warning code kept until fault reset.
// - Warning code reads zero when none recorded.
// - Stop code holds class 1-4 error code.
// - Later class 1-3 errors do not replace stop code.
// - Class 4 error always replaces stop code.
// - Class 0 error sets status bit 7.
// - Class 1-4 error sets status bit 13; class 1-3 is lost at a fault reset while a code is held.
module fld_top (
   input wire logic I_CLOCK,
   input wire logic I_SYS_RST,
   input wire logic [fld_pkg::FLD_SIG_W-1:0] I_MON_SIG,
   input wire logic I_ERR_STB,
   input wire fld_pkg::fld_err_class_t I_ERR_CLASS,
   input wire logic [fld_pkg::FLD_CODE_W-1:0] I_ERR_CODE,
   input wire logic I_FAULT_RST,
   input wire logic I_RD_STB,
   input wire logic [fld_pkg::FLD_ADDR_W-1:0] I_RD_ADDR,
   output logic [fld_pkg::FLD_DATA_W-1:0] O_RD_DATA,
   output logic O_RD_VALID,
   output logic O_RD_ERR,
   output logic [fld_pkg::FLD_STAT_W-1:0] O_STATUS_WORD,
   output logic O_STATUS_CHG
);
   import fld_pkg::*;

   // =========================================================
   // Declarations
   // =========================================================
   logic [FLD_SIG_W-1:0] mon_sync;
   logic [FLD_SIG_W-1:0] mon_set;
   logic [FLD_SIG_W-1:0] latch_r;
   logic [FLD_SIG_W-1:0] latch_nxt;
   logic [FLD_CODE_W-1:0] warn_r;
   logic [FLD_CODE_W-1:0] warn_nxt;
   logic warn_take;
   logic warn_flag_r;
   logic warn_flag_nxt;
   logic stop_take;
   logic [FLD_CODE_W-1:0] stop_code;
   logic stop_flag_r;
   logic stop_flag_nxt;
   logic chg_nxt;
   logic chg_r;
   logic [FLD_STAT_W-1:0] stat_nxt;
   logic [FLD_STAT_W-1:0] stat_r;
   logic sel_stop;
   logic sel_latch;
   logic sel_warn;
   logic rd_hit;
   logic [FLD_DATA_W-1:0] rd_mux;
   logic [FLD_DATA_W-1:0] rd_data_r;
   logic rd_valid_r;
   logic rd_err_r;

   // =========================================================
   // Monitoring inputs
   // =========================================================
   // The monitoring conditions come from outside this clock, so
   // every bit passes two flops before the latch looks at it.
   fld_sync u_sync (
      .i_clk (I_CLOCK),
      .i_rst (I_SYS_RST),
      .i_async (I_MON_SIG),
      .o_sync (mon_sync)
   );

   // =========================================================
   // Monitoring latch
   // =========================================================
   // Reserved positions are masked so that stray wiring on those
   // inputs can never show up in the register.
   assign mon_set = mon_sync & FLD_LATCH_MASK;

   // A fault reset clears the latch, but a condition still active
   // in that cycle sets its bit again at once: set wins.
   assign latch_nxt = (latch_r & {FLD_SIG_W{~I_FAULT_RST}}) |
                      mon_set;

   // Latch register.
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         latch_r <= FLD_LATCH_RST;
      end else begin
         latch_r <= latch_nxt;
      end
   end

   // =========================================================
   // Warning code (class 0)
   // =========================================================
   // A zero code is ignored: zero is reserved to mean "no class 0
   // error", and storing it would make a recorded error invisible.
   assign warn_take = I_ERR_STB && (I_ERR_CLASS == FLD_CLS_0) &&
                      (I_ERR_CODE != FLD_CODE_RST);

   // The code outlives its condition and is dropped only by a
   // fault reset; a new code in the same cycle wins.
   assign warn_nxt = warn_take ? I_ERR_CODE :
                     I_FAULT_RST ? FLD_CODE_RST : warn_r;

   // Warning code register.
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         warn_r <= FLD_CODE_RST;
      end else begin
         warn_r <= warn_nxt;
      end
   end

   // =========================================================
   // Stop code (classes 1 to 4)
   // =========================================================
   fld_stop_code u_stop (
      .i_clk (I_CLOCK),
      .i_rst (I_SYS_RST),
      .i_err_stb (I_ERR_STB),
      .i_err_class (I_ERR_CLASS),
      .i_err_code (I_ERR_CODE),
      .i_fault_clr (I_FAULT_RST),
      .o_take (stop_take),
      .o_code (stop_code)
   );

   // =========================================================
   // Process status bits
   // =========================================================
   // Both error flags are sticky until a fault reset; an error in
   // the reset cycle keeps its flag set, except a class 1-3 error while a stop code is held, which is refused.
   assign warn_flag_nxt = warn_take |
                          (warn_flag_r & ~I_FAULT_RST);
   assign stop_flag_nxt = stop_take |
                          (stop_flag_r & ~I_FAULT_RST);

   // Only bits 7 and 13 are driven here; the rest of the status
   // word belongs to the state machine and is left at zero.
   always_comb begin
      stat_nxt = '0;
      stat_nxt[FLD_STAT_WARN_BIT] = warn_flag_nxt;
      stat_nxt[FLD_STAT_STOP_BIT] = stop_flag_nxt;
   end

   // The status word is sent on change, so flag each change.
   assign chg_nxt = (stat_nxt != stat_r);

   // Status flag registers.
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         warn_flag_r <= 1'b0;
         stop_flag_r <= 1'b0;
         stat_r <= '0;
         chg_r <= 1'b0;
      end else begin
         warn_flag_r <= warn_flag_nxt;
         stop_flag_r <= stop_flag_nxt;
         stat_r <= stat_nxt;
         chg_r <= chg_nxt;
      end
   end

   // =========================================================
   // Parameter read port
   // =========================================================
   // All three registers are read-only; there is no write path,
   // so a master cannot forge or clear a diagnostic code.
   assign sel_stop = (I_RD_ADDR == FLD_ADR_STOP_CODE);
   assign sel_latch = (I_RD_ADDR == FLD_ADR_SIG_LATCH);
   assign sel_warn = (I_RD_ADDR == FLD_ADR_WARN_CODE);
   assign rd_hit = sel_stop | sel_latch | sel_warn;

   // Narrow codes sit in the low half; upper bits read as zero.
   assign rd_mux = sel_latch ? latch_r :
                   sel_warn ? {16'h0000, warn_r} :
                   sel_stop ? {16'h0000, stop_code} :
                   FLD_DATA_RST;

   // Read answer, one cycle after the strobe.
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         rd_data_r <= FLD_DATA_RST;
         rd_valid_r <= 1'b0;
         rd_err_r <= 1'b0;
      end else begin
         rd_data_r <= I_RD_STB ? rd_mux : rd_data_r;
         rd_valid_r <= I_RD_STB;
         rd_err_r <= I_RD_STB & ~rd_hit;
      end
   end

   // =========================================================
   // Outputs
   // =========================================================
   assign O_RD_DATA = rd_data_r;
   assign O_RD_VALID = rd_valid_r;
   assign O_RD_ERR = rd_err_r;
   assign O_STATUS_WORD = stat_r;
   assign O_STATUS_CHG = chg_r;

   // =========================================================
   // Checks
   // =========================================================
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_SYS_RST);

   property p_latch_set;
      (mon_set != '0) |=> ((latch_r & $past(mon_set)) == $past(mon_set));
   endproperty
   a_latch_set: assert property (p_latch_set)
      else $error("Active monitoring condition not latched.");

   property p_reserved;
      (latch_r & FLD_RSV_MASK) == '0;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("Reserved latch bit is set.");

   property p_latch_hold;
      !I_FAULT_RST |=> ((latch_r & $past(latch_r)) == $past(latch_r));
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("Latch bit dropped without a fault reset.");

   property p_warn_take;
      warn_take |=> (warn_r == $past(I_ERR_CODE));
   endproperty
   a_warn_take: assert property (p_warn_take)
      else $error("Class 0 code not captured.");

   property p_warn_keep;
      (!I_FAULT_RST && !warn_take) |=> $stable(warn_r);
   endproperty
   a_warn_keep: assert property (p_warn_keep)
      else $error("Warning code changed without cause.");

   property p_warn_clr;
      (I_FAULT_RST && !warn_take) |=> (warn_r == FLD_CODE_RST) ##1
         ($past(warn_take) || (warn_r == FLD_CODE_RST));
   endproperty
   a_warn_clr: assert property (p_warn_clr)
      else $error("Warning code not zero after fault reset.");

   property p_stat_warn;
      warn_take |=> O_STATUS_WORD[FLD_STAT_WARN_BIT];
   endproperty
   a_stat_warn: assert property (p_stat_warn)
      else $error("Status bit 7 not set on class 0 error.");

   property p_stat_stop;
      stop_take |=> (O_STATUS_WORD[FLD_STAT_STOP_BIT] &&
                     (stop_code != FLD_CODE_RST));
   endproperty
   a_stat_stop: assert property (p_stat_stop)
      else $error("Status bit 13 or stop code missing.");

   property p_rd_latch;
      (I_RD_STB && sel_latch) |=>
         (O_RD_VALID && !O_RD_ERR && (O_RD_DATA == $past(latch_r)));
   endproperty
   a_rd_latch: assert property (p_rd_latch)
      else $error("Latch read returned wrong data.");

   property p_rd_warn;
      (I_RD_STB && sel_warn) |=>
         (O_RD_VALID && !O_RD_ERR &&
          (O_RD_DATA == {16'h0000, $past(warn_r)}));
   endproperty
   a_rd_warn: assert property (p_rd_warn)
      else $error("Warning code read returned wrong data.");

   property p_rd_stop;
      (I_RD_STB && sel_stop) |=>
         (O_RD_VALID && !O_RD_ERR &&
          (O_RD_DATA == {16'h0000, $past(stop_code)}));
   endproperty
   a_rd_stop: assert property (p_rd_stop)
      else $error("Stop code read returned wrong data.");

   // Zero in the warning code must mean that no class 0 error is
   // pending, or a master would miss a recorded error.
   property p_warn_zero;
      (warn_r == FLD_CODE_RST) == !warn_flag_r;
   endproperty
   a_warn_zero: assert property (p_warn_zero)
      else $error("Warning code and status bit 7 disagree.");

   property p_warn_set_wins;
      (warn_take && I_FAULT_RST) |=>
         ((warn_r == $past(I_ERR_CODE)) &&
          O_STATUS_WORD[FLD_STAT_WARN_BIT]);
   endproperty
   a_warn_set_wins: assert property (p_warn_set_wins)
      else $error("Fault reset lost a class 0 error of the same cycle.");

   property p_stop_clr;
      (I_FAULT_RST && !stop_take) |=>
         (!O_STATUS_WORD[FLD_STAT_STOP_BIT] && (stop_code == FLD_CODE_RST));
   endproperty
   a_stop_clr: assert property (p_stop_clr)
      else $error("Fault reset did not clear bit 13 and the stop code.");

   // The change flag is what makes the status word go out, so it
   // must rise exactly when the word moves.
   property p_chg;
      !$past(I_SYS_RST) |->
         (O_STATUS_CHG == (O_STATUS_WORD != $past(O_STATUS_WORD)));
   endproperty
   a_chg: assert property (p_chg)
      else $error("Status change flag does not match the status word.");

endmodule : fld_top

// File: fld_master_model.sv
// Fieldbus master model that issues parameter reads on the read port.
`timescale 1ns/1ps

module fld_master_model (
   input wire logic i_clk,
   input wire logic [fld_pkg::FLD_DATA_W-1:0] i_rd_data,
   input wire logic i_rd_valid,
   input wire logic i_rd_err,
   output logic o_rd_stb,
   output logic [fld_pkg::FLD_ADDR_W-1:0] o_rd_addr
);
   import fld_pkg::*;

   // =========================================================
   // Idle state
   // =========================================================
   // The port is quiet from time zero so no read leaks into reset.
   initial begin
      o_rd_stb = 1'b0;
      o_rd_addr = 16'h0000;
   end

   // =========================================================
   // Read access
   // =========================================================
   // One strobe cycle, then the answer is taken while valid stands.
   // The bench calls this from rd_chk, also right after reset before any error is flagged.
   task automatic rd(input logic [15:0] a, output logic [31:0] d,
                     output logic v, output logic e);
      @(negedge i_clk);
      o_rd_stb = 1'b1;
      o_rd_addr = a;
      @(negedge i_clk);
      o_rd_stb = 1'b0;
      // A released address shows its inverse, so stale reuse is caught.
      o_rd_addr = ~a;
      v = i_rd_valid;
      d = i_rd_data;
      e = i_rd_err;
   endtask : rd

endmodule : fld_master_model

// File: tb_top.sv
// Self-checking testbench for the fault latch diagnostics block.
`timescale 1ns/1ps

module tb_top;
   import fld_pkg::*;

   logic clk;
   logic sys_rst;
   logic [31:0] mon_sig;
   logic err_stb;
   logic [2:0] err_cls;
   logic [15:0] err_code;
   logic fault_rst;
   logic rd_stb;
   logic [15:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_valid;
   logic rd_err;
   logic [15:0] status_word;
   logic status_chg;
   int mismatches;
   int compares;
   logic [31:0] exp_latch;
   int rsv[6] = '{7, 9, 12, 19, 24, 25};

   fld_top i_fld_top (
      .I_CLOCK(clk),
      .I_SYS_RST(sys_rst),
      .I_MON_SIG(mon_sig),
      .I_ERR_STB(err_stb),
      .I_ERR_CLASS(fld_err_class_t'(err_cls)),
      .I_ERR_CODE(err_code),
      .I_FAULT_RST(fault_rst),
      .I_RD_STB(rd_stb),
      .I_RD_ADDR(rd_addr),
      .O_RD_DATA(rd_data),
      .O_RD_VALID(rd_valid),
      .O_RD_ERR(rd_err),
      .O_STATUS_WORD(status_word),
      .O_STATUS_CHG(status_chg)
   );

   fld_master_model i_fld_master_model (
      .i_clk(clk),
      .i_rd_data(rd_data),
      .i_rd_valid(rd_valid),
      .i_rd_err(rd_err),
      .o_rd_stb(rd_stb),
      .o_rd_addr(rd_addr)
   );

   // =========================================================
   // Clock and watchdog
   // =========================================================
   // 40 MHz clock.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // A hang is cut short after a bounded number of cycles.
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end

   // =========================================================
   // Helpers
   // =========================================================
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Reads one parameter and compares data, valid and error flag.
   task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp,
                         input logic exp_err);
      logic [31:0] d;
      logic v;
      logic e;
      i_fld_master_model.rd(a, d, v, e);
      chk("rd_valid", {31'h0, v}, 32'h1);
      chk("rd_err", {31'h0, e}, {31'h0, exp_err});
      chk("rd_data", d, exp);
   endtask : rd_chk

   // One error event; the status word is seen after its edge lands.
   task automatic ev(input logic [2:0] c, input logic [15:0] code,
                     input logic [15:0] exp_stat, input logic exp_chg);
      @(negedge clk);
      err_stb = 1'b1;
      err_cls = c;
      err_code = code;
      @(negedge clk);
      err_stb = 1'b0;
      chk("status_word", {16'h0, status_word}, {16'h0, exp_stat});
      chk("status_chg", {31'h0, status_chg}, {31'h0, exp_chg});
   endtask : ev

   task automatic pulse_fault_rst();
      @(negedge clk);
      fault_rst = 1'b1;
      @(negedge clk);
      fault_rst = 1'b0;
   endtask : pulse_fault_rst

   task automatic report_and_stop();
      $display("Counts: compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   // =========================================================
   // Main sequence
   // =========================================================
   initial begin
      sys_rst = 1'b1;
      mon_sig = 32'h0;
      err_stb = 1'b0;
      err_cls = 3'h0;
      err_code = 16'h0;
      fault_rst = 1'b0;
      mismatches = 0;
      compares = 0;
      repeat (5) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;

      // Everything reads zero after reset; a hole in the map is refused.
      rd_chk(16'h1c12, 32'h0, 1'b0);
      rd_chk(16'h1c0a, 32'h0, 1'b0);
      rd_chk(16'h1c10, 32'h0, 1'b0);
      rd_chk(16'h1c11, 32'h0, 1'b1);
      $display("Test reset values done");

      // Every condition fires once, then goes away; latch must hold.
      exp_latch = 32'hffff_ffff;
      foreach (rsv[i]) exp_latch[rsv[i]] = 1'b0;
      mon_sig = 32'hffff_ffff;
      repeat (4) @(negedge clk);
      mon_sig = 32'h0;
      repeat (4) @(negedge clk);
      rd_chk(16'h1c10, exp_latch, 1'b0);
      // A condition still active survives the fault reset.
      mon_sig = 32'h0000_0008;
      repeat (4) @(negedge clk);
      pulse_fault_rst();
      rd_chk(16'h1c10, 32'h0000_0008, 1'b0);
      mon_sig = 32'h0;
      repeat (4) @(negedge clk);
      pulse_fault_rst();
      rd_chk(16'h1c10, 32'h0, 1'b0);
      $display("Test monitoring latch done");

      // Warning codes: newest class 0 code wins, code 0 is no event.
      ev(3'h0, 16'h0011, 16'h0080, 1'b1);
      rd_chk(16'h1c12, 32'h0000_0011, 1'b0);
      ev(3'h0, 16'h0022, 16'h0080, 1'b0);
      ev(3'h0, 16'h0000, 16'h0080, 1'b0);
      rd_chk(16'h1c12, 32'h0000_0022, 1'b0);
      $display("Test warning code done");

      // Stop codes: first one holds, only class 4 replaces it.
      ev(3'h2, 16'h0123, 16'h2080, 1'b1);
      rd_chk(16'h1c0a, 32'h0000_0123, 1'b0);
      ev(3'h1, 16'h0200, 16'h2080, 1'b0);
      ev(3'h3, 16'h0300, 16'h2080, 1'b0);
      ev(3'h5, 16'h0500, 16'h2080, 1'b0);
      rd_chk(16'h1c0a, 32'h0000_0123, 1'b0);
      ev(3'h4, 16'h0400, 16'h2080, 1'b0);
      rd_chk(16'h1c0a, 32'h0000_0400, 1'b0);
      ev(3'h4, 16'h0401, 16'h2080, 1'b0);
      rd_chk(16'h1c0a, 32'h0000_0401, 1'b0);
      rd_chk(16'h1c12, 32'h0000_0022, 1'b0);
      $display("Test stop code done");

      // Fault reset clears both codes and both status bits.
      @(negedge clk);
      fault_rst = 1'b1;
      @(negedge clk);
      fault_rst = 1'b0;
      chk("status_word", {16'h0, status_word}, 32'h0);
      chk("status_chg", {31'h0, status_chg}, 32'h1);
      rd_chk(16'h1c12, 32'h0, 1'b0);
      rd_chk(16'h1c0a, 32'h0, 1'b0);
      // After the clear a class 1 error is taken again.
      ev(3'h1, 16'h0101, 16'h2000, 1'b1);
      rd_chk(16'h1c0a, 32'h0000_0101, 1'b0);
      // A fault reset held over a class 0 error: the error survives.
      fault_rst = 1'b1;
      ev(3'h0, 16'h0033, 16'h0080, 1'b1);
      fault_rst = 1'b0;
      rd_chk(16'h1c12, 32'h0000_0033, 1'b0);
      rd_chk(16'h1c0a, 32'h0, 1'b0);
      $display("Test fault reset done");

      report_and_stop();
   end

endmodule : tb_top
